/* File: tcpr_position_ref.sv */
// Overview of operation
// - freewheel length 4 to 40, steps 4
// - freewheel until code returns or count ends
// - generate mode ignores freewheel length
// - clamp requested length into 4..40
// - sources: LTC, VITC, auto, serial, biphase
// - auto mode follows the better reader
// - auto lights both LEDs plus point
// - VITC when slow, LTC when shuttling
// - video ref keeps black burst lock
// - biphase needs start frame and ppf
// - start frame held as h/m/s/f fields
// - biphase reset loads host location, display
// - pulses per frame from 2 to 254
// - direction: quadrature order or tach level
//
// Design decisions made here: the address map and the plain strobed port.
`include "tcpr_params.svh"
`timescale 1ns/1ps
`default_nettype none

module tcpr_position_ref (
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        reset_n,
	// register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	// frame clock tick
	input  wire logic        frame_tick,
	// time code readers
	input  wire logic [31:0] ltc_tc,
	input  wire logic        ltc_ok,
	input  wire logic        ltc_fast,
	input  wire logic [31:0] vitc_tc,
	input  wire logic        vitc_ok,
	input  wire logic [31:0] ser0_tc,
	input  wire logic        ser0_ok,
	input  wire logic [31:0] ser1_tc,
	input  wire logic        ser1_ok,
	// biphase pins
	input  wire logic        biph_a,
	input  wire logic        biph_b,
	// video presence
	input  wire logic        video_ref_ok,
	input  wire logic        video_in_ok,
	// position out
	output logic      [31:0] pos_tc_q,
	output logic             pos_valid_q,
	output logic             freewheeling_q,
	output logic      [31:0] disp_tc_q,
	// indicators
	output logic             ind_ltc_q,
	output logic             ind_vitc_q,
	output logic             ind_biph_q,
	output logic             disp_point_q,
	output logic             ref_resolved_q
);

	tcpr_bph_if bph ();

	logic [31:0]          ctrl_q, ctrl_d;
	logic [7:0]           fwlen_q, fwlen_d;
	logic [7:0]           ppf_q, ppf_d;
	logic [1:0]           dir_q, dir_d;
	tcpr_pkg::tcpr_hmsf_t start_q, start_d;
	tcpr_pkg::tcpr_hmsf_t hostloc_q, hostloc_d;
	logic                 load_q, load_d;
	logic [31:0]          rdata_d;
	logic [1:0]           a_sync_q, b_sync_q;

	tcpr_pkg::tcpr_src_t  src;
	logic                 gen_mode;
	logic [7:0]           fps;
	logic [7:0]           wr_len;
	logic                 wr_hit;

	tcpr_pkg::tcpr_hmsf_t pos_q, pos_d;
	logic                 valid_q, valid_d;
	logic                 fwing_q, fwing_d;
	logic [7:0]           fwcnt_q, fwcnt_d;
	logic                 auto_ltc_q, auto_ltc_d;
	tcpr_pkg::tcpr_hmsf_t disp_d;
	logic                 ind_ltc_d, ind_vitc_d, ind_biph_d, point_d, resolved_d;
	tcpr_pkg::tcpr_hmsf_t sel_tc;
	logic                 sel_ok;

	assign src      = tcpr_pkg::tcpr_src_t'(ctrl_q[`TCPR_CTRL_SRC_LSB +: 3]);
	assign gen_mode = ctrl_q[`TCPR_CTRL_GEN_BIT];
	assign fps      = ctrl_q[`TCPR_CTRL_FPS_LSB +: 8];
	assign wr_len   = (reg_wdata[31:8] != 24'h000000) ? 8'hFF : reg_wdata[7:0];

	////////////////////////////////////////////////////////////////////////////////
	// biphase pins cross in through two flops
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			a_sync_q <= 2'b00;
			b_sync_q <= 2'b00;
		end
		else
		begin
			a_sync_q <= {a_sync_q[0], biph_a};
			b_sync_q <= {b_sync_q[0], biph_b};
		end
	end

	assign bph.line_a = a_sync_q[1];
	assign bph.line_b = b_sync_q[1];
	assign bph.pulses_each_frame    = ppf_q;
	assign bph.dir    = tcpr_pkg::tcpr_dir_t'(dir_q);
	assign bph.fps    = fps;
	assign bph.load   = load_q;
	assign bph.start  = start_q;

	tcpr_biphase_counter u_counter (
		.mclk    (mclk),
		.reset_n (reset_n),
		.bph     (bph)
	);

	////////////////////////////////////////////////////////////////////////////////
	// register file
	always_comb
	begin
		ctrl_d    = ctrl_q;
		fwlen_d   = fwlen_q;
		ppf_d     = ppf_q;
		dir_d     = dir_q;
		start_d   = start_q;
		hostloc_d = hostloc_q;
		load_d    = 1'b0;
		wr_hit    = reg_wr;
		if (wr_hit)
		begin
			case (reg_addr)
				`TCPR_ADDR_CTRL:    ctrl_d = reg_wdata;
				`TCPR_ADDR_FWLEN:
				begin
					if (wr_len < `TCPR_FW_MIN)
						fwlen_d = `TCPR_FW_MIN;
					else if (wr_len > `TCPR_FW_MAX)
						fwlen_d = `TCPR_FW_MAX;
					else
						fwlen_d = {wr_len[7:2], 2'b00};
				end
				`TCPR_ADDR_PPF:
				begin
					if (wr_len < `TCPR_PPF_MIN)
						ppf_d = `TCPR_PPF_MIN;
					else if (wr_len > `TCPR_PPF_MAX)
						ppf_d = `TCPR_PPF_MAX;
					else
						ppf_d = wr_len;
				end
				`TCPR_ADDR_DIR:     dir_d = reg_wdata[1:0];
				`TCPR_ADDR_START:
				begin
					start_d = reg_wdata;
					load_d  = 1'b1;
				end
				`TCPR_ADDR_HOSTLOC: hostloc_d = reg_wdata;
				`TCPR_ADDR_CMD:
				begin
					if (reg_wdata[`TCPR_CMD_BPRST_BIT])
					begin
						start_d = hostloc_q;
						load_d  = 1'b1;
					end
				end
				default:            ctrl_d = ctrl_q;
			endcase
		end
		rdata_d = 32'h00000000;
		if (reg_rd)
		begin
			case (reg_addr)
				`TCPR_ADDR_CTRL:    rdata_d = ctrl_q;
				`TCPR_ADDR_FWLEN:   rdata_d = {24'h000000, fwlen_q};
				`TCPR_ADDR_PPF:     rdata_d = {24'h000000, ppf_q};
				`TCPR_ADDR_DIR:     rdata_d = {30'h00000000, dir_q};
				`TCPR_ADDR_START:   rdata_d = start_q;
				`TCPR_ADDR_HOSTLOC: rdata_d = hostloc_q;
				`TCPR_ADDR_STATUS:  rdata_d = {16'h0000, fwcnt_q, 1'b0, bph.fwd,
					bph.loaded, auto_ltc_q, ref_resolved_q, fwing_q, valid_q, sel_ok};
				`TCPR_ADDR_POS:     rdata_d = pos_q;
				default:            rdata_d = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			ctrl_q    <= `TCPR_CTRL_RST;
			fwlen_q   <= `TCPR_FWLEN_RST;
			ppf_q     <= `TCPR_PPF_RST;
			dir_q     <= 2'h0;
			start_q   <= '0;
			hostloc_q <= '0;
			load_q    <= 1'b0;
			reg_rdata <= 32'h00000000;
		end
		else
		begin
			ctrl_q    <= ctrl_d;
			fwlen_q   <= fwlen_d;
			ppf_q     <= ppf_d;
			dir_q     <= dir_d;
			start_q   <= start_d;
			hostloc_q <= hostloc_d;
			load_q    <= load_d;
			reg_rdata <= rdata_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// source selection and position tracking
	always_comb
	begin
		if (ltc_ok && vitc_ok)
			auto_ltc_d = ltc_fast;
		else if (ltc_ok)
			auto_ltc_d = 1'b1;
		else if (vitc_ok)
			auto_ltc_d = 1'b0;
		else
			auto_ltc_d = auto_ltc_q;
		ind_ltc_d  = 1'b0;
		ind_vitc_d = 1'b0;
		ind_biph_d = 1'b0;
		point_d    = 1'b0;
		case (src)
			tcpr_pkg::SRC_LTC:
			begin
				sel_tc    = ltc_tc;
				sel_ok    = ltc_ok;
				ind_ltc_d = 1'b1;
			end
			tcpr_pkg::SRC_VITC:
			begin
				sel_tc     = vitc_tc;
				sel_ok     = vitc_ok;
				ind_vitc_d = 1'b1;
			end
			tcpr_pkg::SRC_AUTO:
			begin
				sel_tc     = auto_ltc_d ? ltc_tc : vitc_tc;
				sel_ok     = auto_ltc_d ? ltc_ok : vitc_ok;
				ind_ltc_d  = 1'b1;
				ind_vitc_d = 1'b1;
				point_d    = 1'b1;
			end
			tcpr_pkg::SRC_SER0:
			begin
				sel_tc = ser0_tc;
				sel_ok = ser0_ok;
			end
			tcpr_pkg::SRC_SER1:
			begin
				sel_tc = ser1_tc;
				sel_ok = ser1_ok;
			end
			tcpr_pkg::SRC_BIPH:
			begin
				// position only once a start is loaded
				sel_tc     = bph.pos;
				sel_ok     = bph.loaded;
				ind_biph_d = 1'b1;
			end
			default:
			begin
				sel_tc = ltc_tc;
				sel_ok = ltc_ok;
			end
		endcase
		// video ref stays on black burst
		resolved_d = ctrl_q[`TCPR_CTRL_VREF_BIT] ? video_ref_ok : video_in_ok;

		pos_d   = pos_q;
		valid_d = valid_q;
		fwing_d = 1'b0;
		fwcnt_d = fwcnt_q;
		if (gen_mode)
		begin
			if (frame_tick)
				pos_d = tcpr_pkg::tcpr_step(pos_q, fps, 1'b1);
			valid_d = 1'b1;
			fwcnt_d = 8'h00;
		end
		else if (sel_ok)
		begin
			pos_d   = sel_tc;
			valid_d = 1'b1;
			fwcnt_d = 8'h00;
		end
		else if (valid_q && fwcnt_q < fwlen_q)
		begin
			fwing_d = 1'b1;
			if (frame_tick)
			begin
				pos_d = tcpr_pkg::tcpr_step(pos_q, fps, 1'b1);
				fwcnt_d = fwcnt_q + 8'h01;
			end
		end
		else
			valid_d = 1'b0;
		// display follows a fresh start frame
		disp_d = load_q ? start_q : pos_d;
	end

	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			pos_q          <= '0;
			valid_q        <= 1'b0;
			fwing_q        <= 1'b0;
			fwcnt_q        <= 8'h00;
			auto_ltc_q     <= 1'b1;
			pos_tc_q       <= 32'h00000000;
			pos_valid_q    <= 1'b0;
			freewheeling_q <= 1'b0;
			disp_tc_q      <= 32'h00000000;
			ind_ltc_q      <= 1'b0;
			ind_vitc_q     <= 1'b0;
			ind_biph_q     <= 1'b0;
			disp_point_q   <= 1'b0;
			ref_resolved_q <= 1'b0;
		end
		else
		begin
			pos_q          <= pos_d;
			valid_q        <= valid_d;
			fwing_q        <= fwing_d;
			fwcnt_q        <= fwcnt_d;
			auto_ltc_q     <= auto_ltc_d;
			pos_tc_q       <= pos_d;
			pos_valid_q    <= valid_d;
			freewheeling_q <= fwing_d;
			disp_tc_q      <= disp_d;
			ind_ltc_q      <= ind_ltc_d;
			ind_vitc_q     <= ind_vitc_d;
			ind_biph_q     <= ind_biph_d;
			disp_point_q   <= point_d;
			ref_resolved_q <= resolved_d;
		end
	end

endmodule

`default_nettype wire

/* File: tcpr_params.svh */
`ifndef TCPR_PARAMS_SVH
`define TCPR_PARAMS_SVH

// register byte addresses
`define TCPR_ADDR_CTRL     8'h00
`define TCPR_ADDR_FWLEN    8'h04
`define TCPR_ADDR_PPF      8'h08
`define TCPR_ADDR_DIR      8'h0C
`define TCPR_ADDR_START    8'h10
`define TCPR_ADDR_HOSTLOC  8'h14
`define TCPR_ADDR_CMD      8'h18
`define TCPR_ADDR_STATUS   8'h1C
`define TCPR_ADDR_POS      8'h20

// control and command field positions
`define TCPR_CTRL_SRC_LSB  0
`define TCPR_CTRL_GEN_BIT  3
`define TCPR_CTRL_VREF_BIT 4
`define TCPR_CTRL_FPS_LSB  8
`define TCPR_CMD_BPRST_BIT 0

// limits and reset values
`define TCPR_FW_MIN        8'h04
`define TCPR_FW_MAX        8'h28
`define TCPR_PPF_MIN       8'h02
`define TCPR_PPF_MAX       8'hFE
`define TCPR_CTRL_RST      32'h00001E00
`define TCPR_FWLEN_RST     8'h04
`define TCPR_PPF_RST       8'h02
`define TCPR_HOURS_WRAP    8'h18
`define TCPR_MINSEC_WRAP   8'h3C

`endif

/* File: tcpr_pkg.sv */
package tcpr_pkg;

	typedef struct packed {
		logic [7:0] hours;
		logic [7:0] minutes;
		logic [7:0] seconds;
		logic [7:0] frames;
	} tcpr_hmsf_t;

	typedef enum logic [2:0] {
		SRC_LTC,
		SRC_VITC,
		SRC_AUTO,
		SRC_SER0,
		SRC_SER1,
		SRC_BIPH
	} tcpr_src_t;

	typedef enum logic [1:0] {
		DIR_A_LEADS,
		DIR_B_LEADS,
		DIR_TACH_LOW,
		DIR_TACH_HIGH
	} tcpr_dir_t;

	// one frame forward or back, binary fields, 24 hour wrap
	function automatic tcpr_hmsf_t tcpr_step(tcpr_hmsf_t t, logic [7:0] fps, logic up);
		tcpr_hmsf_t r;
		r = t;
		if (up)
		begin
			if (t.frames + 8'h01 < fps)
				r.frames = t.frames + 8'h01;
			else
			begin
				r.frames = 8'h00;
				if (t.seconds < 8'h3B)
					r.seconds = t.seconds + 8'h01;
				else
				begin
					r.seconds = 8'h00;
					if (t.minutes < 8'h3B)
						r.minutes = t.minutes + 8'h01;
					else
					begin
						r.minutes = 8'h00;
						r.hours = (t.hours < 8'h17) ? t.hours + 8'h01 : 8'h00;
					end
				end
			end
		end
		else
		begin
			if (t.frames != 8'h00)
				r.frames = t.frames - 8'h01;
			else
			begin
				r.frames = fps - 8'h01;
				if (t.seconds != 8'h00)
					r.seconds = t.seconds - 8'h01;
				else
				begin
					r.seconds = 8'h3B;
					if (t.minutes != 8'h00)
						r.minutes = t.minutes - 8'h01;
					else
					begin
						r.minutes = 8'h3B;
						r.hours = (t.hours != 8'h00) ? t.hours - 8'h01 : 8'h17;
					end
				end
			end
		end
		return r;
	endfunction

endpackage

/* File: tcpr_bph_if.sv */
`timescale 1ns/1ps
`default_nettype none

interface tcpr_bph_if;
	logic                line_a;
	logic                line_b;
	logic [7:0]          pulses_each_frame;
	tcpr_pkg::tcpr_dir_t dir;
	logic [7:0]          fps;
	logic                load;
	tcpr_pkg::tcpr_hmsf_t start;
	tcpr_pkg::tcpr_hmsf_t pos;
	logic                loaded;
	logic                fwd;

	modport ctl (output line_a, line_b, pulses_each_frame, dir, fps, load, start, input pos, loaded, fwd);
	modport cnt (input line_a, line_b, pulses_each_frame, dir, fps, load, start, output pos, loaded, fwd);
endinterface

`default_nettype wire

/* File: tcpr_biphase_counter.sv */
`timescale 1ns/1ps
`default_nettype none

module tcpr_biphase_counter (
	// clock and reset
	input  wire logic mclk,
	input  wire logic reset_n,
	// counter side
	tcpr_bph_if.cnt   bph
);

	logic                 a_prev_q, a_prev_d;
	logic [7:0]           pulse_q, pulse_d;
	tcpr_pkg::tcpr_hmsf_t pos_q, pos_d;
	logic                 loaded_q, loaded_d;
	logic                 fwd_q, fwd_d;
	logic                 a_rise;
	logic                 dir_fwd;

	assign a_rise = bph.line_a & ~a_prev_q;

	////////////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		a_prev_d = bph.line_a;
		pulse_d  = pulse_q;
		pos_d    = pos_q;
		loaded_d = loaded_q;
		case (bph.dir)
			tcpr_pkg::DIR_A_LEADS:   dir_fwd = ~bph.line_b;
			tcpr_pkg::DIR_B_LEADS:   dir_fwd = bph.line_b;
			tcpr_pkg::DIR_TACH_LOW:  dir_fwd = ~bph.line_b;
			tcpr_pkg::DIR_TACH_HIGH: dir_fwd = bph.line_b;
			default:                 dir_fwd = 1'b1;
		endcase
		fwd_d = a_rise ? dir_fwd : fwd_q;
		if (bph.load)
		begin
			pos_d    = bph.start;
			pulse_d  = 8'h00;
			loaded_d = 1'b1;
		end
		else if (a_rise && loaded_q)
		begin
			if (pulse_q + 8'h01 >= bph.pulses_each_frame)
			begin
				pulse_d = 8'h00;
				pos_d   = tcpr_pkg::tcpr_step(pos_q, bph.fps, dir_fwd);
			end
			else
				pulse_d = pulse_q + 8'h01;
		end
	end

	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			a_prev_q <= 1'b0;
			pulse_q  <= 8'h00;
			pos_q    <= '0;
			loaded_q <= 1'b0;
			fwd_q    <= 1'b1;
		end
		else
		begin
			a_prev_q <= a_prev_d;
			pulse_q  <= pulse_d;
			pos_q    <= pos_d;
			loaded_q <= loaded_d;
			fwd_q    <= fwd_d;
		end
	end

	assign bph.pos    = pos_q;
	assign bph.loaded = loaded_q;
	assign bph.fwd    = fwd_q;

endmodule

`default_nettype wire

/* File: tcpr_position_ref_checker.sv */
`timescale 1ns/1ps
`default_nettype none

module tcpr_position_ref_checker (
	// clock and reset
	input wire logic	mclk,
	input wire logic	reset_n,
	// inputs seen
	input wire logic	frame_tick,
	input wire logic [31:0]	ltc_tc,
	input wire logic	ltc_ok,
	input wire logic	ltc_fast,
	input wire logic [31:0]	vitc_tc,
	input wire logic	vitc_ok,
	input wire logic	video_ref_ok,
	input wire logic	video_in_ok,
	// outputs watched
	input wire logic [31:0]	pos_tc_q,
	input wire logic	pos_valid_q,
	input wire logic	freewheeling_q,
	input wire logic	ind_ltc_q,
	input wire logic	ind_vitc_q,
	input wire logic	disp_point_q,
	input wire logic	ref_resolved_q
);
	default clocking @(posedge mclk);
	endclocking
	default disable iff (!reset_n);
	logic [7:0]	fw_cnt_q;
	logic	auto_on;
	assign auto_on = ind_ltc_q && ind_vitc_q;
	// ticks seen while coasting, cleared once code is back
	always_ff @(posedge mclk or negedge reset_n)
		if (!reset_n)
			fw_cnt_q <= 8'h00;
		else
			fw_cnt_q <= freewheeling_q ? fw_cnt_q + 8'(frame_tick) : 8'h00;
	sequence s_coast_tick;
		freewheeling_q && frame_tick ##1 freewheeling_q;
	endsequence
	sequence s_coast_idle;
		freewheeling_q && !frame_tick ##1 freewheeling_q;
	endsequence
	sequence s_auto_fast;
		auto_on && ltc_ok && ltc_fast ##1 auto_on;
	endsequence
	sequence s_auto_slow;
		auto_on && vitc_ok && !ltc_fast ##1 auto_on;
	endsequence
	a_coast_valid: assert property (freewheeling_q |-> pos_valid_q)
		else $error("coasting without valid position");
	a_coast_limit: assert property (fw_cnt_q <= 8'h28)
		else $error("coasting past forty frames");
	a_coast_step: assert property (s_coast_tick |-> pos_tc_q != $past(pos_tc_q))
		else $error("coast tick did not advance");
	a_coast_hold: assert property (s_coast_idle |-> $stable(pos_tc_q))
		else $error("coast moved without tick");
	a_auto_fast: assert property (s_auto_fast |-> pos_tc_q == $past(ltc_tc))
		else $error("auto did not pick fast linear code");
	a_auto_slow: assert property (s_auto_slow |-> pos_tc_q == $past(vitc_tc))
		else $error("auto did not pick slow interval code");
	a_auto_point: assert property (auto_on == disp_point_q)
		else $error("auto point out of step with lamps");
	a_ref_burst: assert property ((video_ref_ok == video_in_ok) |=> ref_resolved_q == $past(video_ref_ok))
		else $error("resolve flag wrong");
endmodule

bind tcpr_position_ref tcpr_position_ref_checker tcpr_position_ref_checker_inst (
	.mclk, .reset_n, .frame_tick, .ltc_tc, .ltc_ok, .ltc_fast, .vitc_tc, .vitc_ok,
	.video_ref_ok, .video_in_ok, .pos_tc_q, .pos_valid_q, .freewheeling_q,
	.ind_ltc_q, .ind_vitc_q, .disp_point_q, .ref_resolved_q);

`default_nettype wire

/* File: tcpr_transport_model.sv */
`timescale 1ns/1ps
`default_nettype none

module tcpr_transport_model (
	// clock and reset
	input wire logic	mclk,
	input wire logic	reset_n,
	// motion
	input wire logic [31:0]	cue,
	input wire logic	moving,
	input wire logic	shuttle,
	input wire logic	drop,
	input wire logic	spin,
	input wire logic	rev,
	input wire logic	tach,
	// readers and pins
	output logic [31:0]	ltc_tc,
	output logic	ltc_ok,
	output logic	ltc_fast,
	output logic [31:0]	vitc_tc,
	output logic	vitc_ok,
	output logic [31:0]	ser0_tc,
	output logic	ser0_ok,
	output logic [31:0]	ser1_tc,
	output logic	ser1_ok,
	output logic	biph_a,
	output logic	biph_b
);
	logic [3:0]	ph_q;
	logic [1:0]	ph;
	// parked on the start frame: pins stand still until spun
	// parked transport
	always_ff @(posedge mclk or negedge reset_n)
		if (!reset_n)
			ph_q <= 4'h0;
		else
			ph_q <= spin ? ph_q + 4'h1 : 4'h0;
	assign ph = ph_q[3:2];
	assign biph_a = rev ? ph[1] : ph[1] ^ ph[0];
	assign biph_b = tach ? rev : (rev ? ph[1] ^ ph[0] : ph[1]);
	// linear code unreadable parked, interval code unreadable shuttling
	assign ltc_ok = !drop && moving;
	assign vitc_ok = !drop && !shuttle;
	assign ltc_fast = shuttle;
	assign ser0_ok = !drop;
	assign ser1_ok = !drop;
	// a lost reader shows garbage, not the last code
	assign ltc_tc = ltc_ok ? cue : ~cue;
	assign vitc_tc = vitc_ok ? cue ^ 32'h00000001 : ~cue;
	assign ser0_tc = ser0_ok ? cue ^ 32'h00000002 : ~cue;
	assign ser1_tc = ser1_ok ? cue ^ 32'h00000003 : ~cue;
endmodule

`default_nettype wire

/* File: tcpr_position_ref_tb_top.sv */
`include "tcpr_params.svh"
`timescale 1ns/1ps
`default_nettype none

module tcpr_position_ref_tb_top;
	logic	mclk, reset_n, reg_wr, reg_rd, frame_tick, video_ref_ok, video_in_ok;
	logic	moving, shuttle, drop, spin, rev, tach;
	logic	ltc_ok, ltc_fast, vitc_ok, ser0_ok, ser1_ok, biph_a, biph_b;
	logic	pos_valid_q, freewheeling_q, ind_ltc_q, ind_vitc_q, ind_biph_q;
	logic	disp_point_q, ref_resolved_q;
	logic [7:0]	reg_addr;
	logic [2:0]	ftc;
	logic [31:0]	reg_wdata, reg_rdata, cue, ltc_tc, vitc_tc, ser0_tc, ser1_tc;
	logic [31:0]	pos_tc_q, disp_tc_q;
	int	n_mismatch, n_checks, cyc;

	tcpr_position_ref tcpr_position_ref_inst (.mclk, .reset_n, .reg_addr, .reg_wdata,
		.reg_wr, .reg_rd, .reg_rdata, .frame_tick, .ltc_tc, .ltc_ok, .ltc_fast, .vitc_tc,
		.vitc_ok, .ser0_tc, .ser0_ok, .ser1_tc, .ser1_ok, .biph_a, .biph_b, .video_ref_ok,
		.video_in_ok, .pos_tc_q, .pos_valid_q, .freewheeling_q, .disp_tc_q, .ind_ltc_q,
		.ind_vitc_q, .ind_biph_q, .disp_point_q, .ref_resolved_q);
	tcpr_transport_model tcpr_transport_model_inst (.mclk, .reset_n, .cue, .moving,
		.shuttle, .drop, .spin, .rev, .tach, .ltc_tc, .ltc_ok, .ltc_fast, .vitc_tc,
		.vitc_ok, .ser0_tc, .ser0_ok, .ser1_tc, .ser1_ok, .biph_a, .biph_b);

	initial
	begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	////////////////////////////////////////////////////////////////////////
	// frame tick every 8 cycles, keeps coasting runs short
	always @(posedge mclk)
	begin
		ftc <= ftc + 3'h1;
		frame_tick <= (ftc == 3'h7);
		cyc <= cyc + 1;
		if (cyc == 8000)
		begin
			n_mismatch++;
			end_of_test();
		end
	end
	////////////////////////////////////////////////////////////////////////
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(string w, logic [31:0] seen, logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", w, exp, seen);
		end
	endtask
	task automatic wr(logic [7:0] a, logic [31:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(string w, logic [7:0] a, logic [31:0] e);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		@(negedge mclk);
		chk(w, reg_rdata, e);
	endtask
	task automatic nap(int n);
		repeat (n) @(negedge mclk);
	endtask
	function automatic logic [31:0] fw_exp(logic [31:0] v);
		return (v < 4) ? 32'h4 : (v > 40) ? 32'h28 : v & 32'hFFFFFFFC;
	endfunction
	function automatic logic [31:0] ppf_exp(logic [31:0] v);
		return (v < 2) ? 32'h2 : (v > 254) ? 32'hFE : v;
	endfunction
	function automatic logic [31:0] rnd_tc();
		return {8'($urandom % 24), 8'($urandom % 60), 8'($urandom % 60), 8'(2 + $urandom % 18)};
	endfunction
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		logic [31:0] v;
		logic [31:0] t;
		logic up;
		{reg_wr, reg_rd, frame_tick, video_ref_ok, video_in_ok} = '0;
		{moving, shuttle, drop, spin, rev, tach} = '0;
		{reg_addr, reg_wdata, cue, ftc} = '0;
		{cyc, n_mismatch, n_checks} = '0;
		reset_n = 1'b0;
		v = $urandom(32'hF2DB6BB8);
		repeat (10) @(posedge mclk);
		reset_n <= 1'b1;
		rd("ctrl", `TCPR_ADDR_CTRL, `TCPR_CTRL_RST);
		rd("fwlen", `TCPR_ADDR_FWLEN, 32'h4);
		rd("ppf", `TCPR_ADDR_PPF, 32'h2);
		rd("unmapped", 8'h24, 32'h0);
		for (int i = 0; i < 12; i++)
		begin
			v = (i == 0) ? 0 : (i == 1) ? 300 : (i == 2) ? 41 : $urandom % 64;
			wr(`TCPR_ADDR_FWLEN, v);
			rd("fwlen", `TCPR_ADDR_FWLEN, fw_exp(v));
			v = (i == 0) ? 1 : (i == 1) ? 255 : (i == 2) ? 254 : $urandom % 260;
			wr(`TCPR_ADDR_PPF, v);
			rd("ppf", `TCPR_ADDR_PPF, ppf_exp(v));
		end
		// each source but biphase in turn, readers moving at play speed
		for (int s = 0; s < 5; s++)
		begin
			t = rnd_tc();
			@(posedge mclk);
			moving <= 1'b1;
			cue <= t;
			wr(`TCPR_ADDR_CTRL, 32'h00001E00 | s);
			nap(3);
			chk("source", pos_tc_q, t ^ ((s == 0) ? 0 : (s < 3) ? 1 : s - 1));
			chk("point", disp_point_q, s == 2);
			chk("lamps", ind_ltc_q && ind_vitc_q, s == 2);
		end
		// back to auto: the source loop leaves serial port 1 selected
		wr(`TCPR_ADDR_CTRL, 32'h00001E02);
		@(posedge mclk);
		shuttle <= 1'b1;
		nap(3);
		chk("auto fast", pos_tc_q, t);
		@(posedge mclk);
		{moving, shuttle} <= 2'b00;
		nap(3);
		chk("auto parked", pos_tc_q, t ^ 32'h1);
		// coast after dropout, lengths 4 and 8
		for (int l = 4; l <= 8; l += 4)
		begin
			wr(`TCPR_ADDR_FWLEN, l);
			wr(`TCPR_ADDR_CTRL, 32'h00001E00);
			@(posedge mclk);
			moving <= 1'b1;
			do @(posedge mclk); while (frame_tick !== 1'b1);
			drop <= 1'b1;
			repeat (8 * l - 1) @(posedge mclk);
			@(negedge mclk);
			chk("coasting", freewheeling_q, 1);
			chk("coast pos", pos_tc_q, t + l - 1);
			// last tick lands one cycle later, coasting drops the cycle after it
			nap(2);
			chk("coast end", {freewheeling_q, pos_valid_q}, 0);
			@(posedge mclk);
			drop <= 1'b0;
			nap(2);
			chk("code back valid", pos_valid_q, 1);
			chk("code back", pos_tc_q, t);
		end
		wr(`TCPR_ADDR_CTRL, 32'h00001E08);
		@(posedge mclk);
		drop <= 1'b1;
		nap(90);
		chk("generate valid", pos_valid_q, 1);
		chk("generate coast", freewheeling_q, 0);
		@(posedge mclk);
		drop <= 1'b0;
		for (int i = 0; i < 8; i++)
		begin
			wr(`TCPR_ADDR_CTRL, 32'h00001E00 | (i[2] << 4));
			{video_in_ok, video_ref_ok} <= i[1:0];
			nap(2);
			chk("resolved", ref_resolved_q, i[2] ? i[0] : i[1]);
		end
		// biphase: park, load host location, spin four pulses
		wr(`TCPR_ADDR_PPF, 32'h2);
		for (int d = 0; d < 4; d++)
		begin
			t = rnd_tc();
			up = $urandom % 2;
			wr(`TCPR_ADDR_DIR, d);
			wr(`TCPR_ADDR_CTRL, 32'h00001E05);
			wr(`TCPR_ADDR_HOSTLOC, t);
			wr(`TCPR_ADDR_CMD, 32'h1);
			rd("start", `TCPR_ADDR_START, t);
			chk("display", disp_tc_q, t);
			chk("load pos", pos_tc_q, t);
			@(posedge mclk);
			{tach, rev, spin} <= {d[1], up, 1'b1};
			repeat (64) @(posedge mclk);
			spin <= 1'b0;
			nap(8);
			chk("biphase", pos_tc_q, (up == d[0]) ? t + 2 : t - 2);
			chk("biphase lamp", ind_biph_q, 1);
			rd("position", `TCPR_ADDR_POS, (up == d[0]) ? t + 2 : t - 2);
		end
		end_of_test();
	end
endmodule

`default_nettype wire
